// >>> ocd_pkg.sv
`default_nettype none
package ocd_pkg;

    localparam int BYTE_W  = 8;
    localparam int ATTR_W  = 5;
    localparam int WORD_W  = 13;
    localparam int ADDR_W  = 8;
    localparam int RAM_DEPTH = 256;

    // command opcodes
    localparam logic [5:0] OP_BANK_SEL   = 6'h1E;
    localparam logic [2:0] OP_ATTR       = 3'h0;
    localparam logic [3:0] OP_ADDR_HI    = 4'h2;
    localparam logic [3:0] OP_ADDR_LO    = 4'h3;
    localparam logic [3:0] OP_FRAME_BG   = 4'h4;
    localparam logic [3:0] OP_MISC       = 4'h5;
    localparam logic [1:0] OP_DIVISOR    = 2'h0;
    localparam logic [3:0] OP_CTRL1      = 4'h4;
    localparam logic [3:0] OP_SYNC       = 4'h5;
    localparam logic [3:0] OP_BLINK      = 4'h6;
    localparam logic [3:0] OP_IO_SEL     = 4'h7;
    localparam logic [3:0] OP_VSTART_HI  = 4'h9;
    localparam logic [3:0] OP_VH_START   = 4'hA;
    localparam logic [3:0] OP_HSTART_LO  = 4'hB;
    localparam logic [1:0] OP_PORT       = 2'h3;

    localparam logic [1:0] BANK_0 = 2'h0;
    localparam logic [1:0] BANK_1 = 2'h1;
    localparam logic [1:0] BANK_2 = 2'h2;

    // reserved display codes
    localparam logic [7:0] CODE_TEST  = 8'hFD;
    localparam logic [7:0] CODE_CR    = 8'hFE;
    localparam logic [7:0] CODE_SPACE = 8'hFF;

    // field positions in a ram word
    localparam int CHAR_LSB = 5;

    // values after reset
    localparam logic [1:0]        RST_BANK     = 2'h0;
    localparam logic [ADDR_W-1:0] RST_PTR      = 8'h00;
    localparam logic [ATTR_W-1:0] RST_ATTR     = 5'h00;
    localparam logic [BYTE_W-1:0] RST_CHAR     = 8'h00;
    localparam logic              RST_POLARITY = 1'b1;
    localparam logic              RST_CLK_EN   = 1'b0;

    typedef struct packed {
        logic [5:0] osc_divisor;
        logic       scan_mode_hi;
        logic       scan_mode_lo;
        logic       video_out_polarity;
        logic       osd_clk_enable;
        logic       hsync_in_polarity;
        logic       vsync_in_polarity;
        logic       display_mode_hi;
        logic       display_mode_lo;
        logic       blink_rate_hi;
        logic       blink_rate_lo;
        logic       blink_duty_hi;
        logic       blink_duty_lo;
        logic       io_port_select;
        logic [5:0] vstart;
        logic [5:0] hstart;
        logic [3:0] frame_bg;
        logic       horiz_stabiliser_enable;
        logic       halftone_select;
        logic       first_line_size_hi;
        logic       first_line_size_lo;
    } ocd_cfg_t;

    localparam ocd_cfg_t RST_CFG = '{
        video_out_polarity: RST_POLARITY,
        osd_clk_enable:     RST_CLK_EN,
        default:            '0
    };

    typedef struct packed {
        logic       red;
        logic       green;
        logic       blue;
        logic       intensity;
        logic       fast_blanking_out;
        logic       record_marker_out;
    } ocd_video_t;

    typedef struct packed {
        logic       is_cr;
        logic       is_space;
        logic [1:0] line_size;
        logic [1:0] line_spacing;
        logic       end_of_screen;
        logic [7:0] code;
    } ocd_line_t;

endpackage
`default_nettype wire

// >>> ocd_decoder.sv
// Function
// - FEh word: transparent, continue on next line
// - FEh word: bits 4-3 size, 2-1 spacing
// - FEh word bit 0 ends current screen
// - FFh word: transparent one-cell, optional background
// - FFh word: bits 4-1 background, bit 0 marker
// - video outputs inactive during retrace
// - 8-bit write pointer, nibbles loaded independently
// - 0010/0011 load pointer nibbles, bank 00
// - attribute staging holds five bits only
// - attribute command 000xxxxx in banks 00, 10
// - attribute staging survives ram writes
// - character staging feeds ram bits 12-5
// - character load writes 13-bit word
// - pointer increments after each write
// - bit 7 set loads character, banks 00/10
// - bank 01 00xxxxxx loads oscillator divisor
// - bank 01 0100 loads scan, polarity, enable
// - bank 01 0101 loads sync polarities, mode
// - bank 01 1001-1011 load start positions
// - bank 01 11xxxxxx drives three port bits
// - bank 00 0100 frame colour, 0101 misc
// - don't-care bits ignored, except 0111 io select needs bits 3, 1, 0 clear; bank select everywhere
// - 011110xx selects command bank
// - reset clears bank flags to 00
// - character word: bits 4-1 colour, 0 blink
`timescale 1ns/1ps
`default_nettype none
module ocd_decoder #(
    parameter bit SPACE_HAS_BG = 1'b0
) (
    input  wire logic                            sys_clk,
    input  wire logic                            sys_rst,
    input  wire logic                            link_clk,
    input  wire logic [ocd_pkg::BYTE_W-1:0]      link_byte,
    input  wire logic                            link_byte_valid,
    input  wire logic                            cell_req,
    input  wire logic [ocd_pkg::ADDR_W-1:0]      cell_addr,
    input  wire logic                            glyph_dot,
    input  wire logic                            blink_hide,
    input  wire logic                            retrace,
    output logic                                 byte_taken,
    output ocd_pkg::ocd_cfg_t                    cfg,
    output logic                                 port_out_bit0,
    output logic                                 port_out_bit1,
    output logic                                 port_out_bit4,
    output logic [1:0]                           bank,
    output logic [ocd_pkg::ADDR_W-1:0]           wr_pointer,
    output logic [ocd_pkg::WORD_W-1:0]           cell_word,
    output logic                                 cell_valid,
    output ocd_pkg::ocd_line_t                   line_info,
    output ocd_pkg::ocd_video_t                  video
);

    // ---------------- link domain ----------------
    logic [ocd_pkg::BYTE_W-1:0] link_hold_ff;
    logic                       link_tgl_ff;

    // the hold word only changes with the toggle, so the system side
    // reads it stable; bytes must be spaced by at least six sys_clk cycles
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_hold_ff <= '0;
            link_tgl_ff  <= 1'b0;
        end else if (link_byte_valid) begin
            link_hold_ff <= link_byte;
            link_tgl_ff  <= ~link_tgl_ff;
        end
    end

    // ---------------- crossing ----------------
    logic tgl_meta_ff;
    logic tgl_sync_ff;
    logic tgl_seen_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_meta_ff <= 1'b0;
            tgl_sync_ff <= 1'b0;
            tgl_seen_ff <= 1'b0;
        end else begin
            tgl_meta_ff <= link_tgl_ff;
            tgl_sync_ff <= tgl_meta_ff;
            tgl_seen_ff <= tgl_sync_ff;
        end
    end

    logic                       rx_stb;
    logic [ocd_pkg::BYTE_W-1:0] rx;

    assign rx_stb     = tgl_sync_ff ^ tgl_seen_ff;
    assign rx         = link_hold_ff;
    assign byte_taken = rx_stb;

    // ---------------- command decode ----------------
    logic bank_flag_hi_ff;
    logic bank_flag_lo_ff;
    logic in_bank0;
    logic in_bank1;
    logic in_bank2;

    assign in_bank0 = {bank_flag_hi_ff, bank_flag_lo_ff} == ocd_pkg::BANK_0;
    assign in_bank1 = {bank_flag_hi_ff, bank_flag_lo_ff} == ocd_pkg::BANK_1;
    assign in_bank2 = {bank_flag_hi_ff, bank_flag_lo_ff} == ocd_pkg::BANK_2;
    assign bank     = {bank_flag_hi_ff, bank_flag_lo_ff};

    logic cmd_bank;
    logic cmd_char;
    logic cmd_attr;
    logic cmd_addr_hi;
    logic cmd_addr_lo;
    logic cmd_frame_bg;
    logic cmd_misc;
    logic cmd_divisor;
    logic cmd_ctrl1;
    logic cmd_sync;
    logic cmd_blink;
    logic cmd_io_sel;
    logic cmd_vstart_hi;
    logic cmd_vh_start;
    logic cmd_hstart_lo;
    logic cmd_port;

    // any byte not caught here falls through with no effect
    always_comb begin
        cmd_bank      = rx_stb && rx[7:2] == ocd_pkg::OP_BANK_SEL;
        cmd_char      = rx_stb && rx[7] && (in_bank0 || in_bank2);
        cmd_attr      = rx_stb && !bank_flag_lo_ff
                        && rx[7:5] == ocd_pkg::OP_ATTR;
        cmd_addr_hi   = rx_stb && in_bank0 && rx[7:4] == ocd_pkg::OP_ADDR_HI;
        cmd_addr_lo   = rx_stb && in_bank0 && rx[7:4] == ocd_pkg::OP_ADDR_LO;
        cmd_frame_bg  = rx_stb && in_bank0 && rx[7:4] == ocd_pkg::OP_FRAME_BG;
        cmd_misc      = rx_stb && in_bank0 && rx[7:4] == ocd_pkg::OP_MISC;
        cmd_divisor   = rx_stb && in_bank1 && rx[7:6] == ocd_pkg::OP_DIVISOR;
        cmd_ctrl1     = rx_stb && in_bank1 && rx[7:4] == ocd_pkg::OP_CTRL1;
        cmd_sync      = rx_stb && in_bank1 && rx[7:4] == ocd_pkg::OP_SYNC;
        cmd_blink     = rx_stb && in_bank1 && rx[7:4] == ocd_pkg::OP_BLINK;
        cmd_io_sel    = rx_stb && in_bank1 && rx[7:4] == ocd_pkg::OP_IO_SEL
                        && !rx[3] && !rx[1] && !rx[0];
        cmd_vstart_hi = rx_stb && in_bank1 && rx[7:4] == ocd_pkg::OP_VSTART_HI;
        cmd_vh_start  = rx_stb && in_bank1 && rx[7:4] == ocd_pkg::OP_VH_START;
        cmd_hstart_lo = rx_stb && in_bank1 && rx[7:4] == ocd_pkg::OP_HSTART_LO;
        cmd_port      = rx_stb && in_bank1 && rx[7:6] == ocd_pkg::OP_PORT;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_flag_hi_ff <= ocd_pkg::RST_BANK[1];
            bank_flag_lo_ff <= ocd_pkg::RST_BANK[0];
        end else if (cmd_bank) begin
            bank_flag_hi_ff <= rx[1];
            bank_flag_lo_ff <= rx[0];
        end
    end

    // ---------------- staging and ram write ----------------
    logic [ocd_pkg::ADDR_W-1:0] display_ram_write_pointer_ff;
    logic [ocd_pkg::ATTR_W-1:0] attribute_staging_ff;
    logic [ocd_pkg::BYTE_W-1:0] character_staging_ff;
    logic [ocd_pkg::BYTE_W-1:0] nxt_char;
    logic                       wr_pend_ff;

    // character bit 7 comes from the bank the load was issued in
    assign nxt_char   = {in_bank2, rx[6:0]};
    assign wr_pointer = display_ram_write_pointer_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            display_ram_write_pointer_ff <= ocd_pkg::RST_PTR;
        end else if (cmd_addr_hi) begin
            display_ram_write_pointer_ff[7:4] <= rx[3:0];
        end else if (cmd_addr_lo) begin
            display_ram_write_pointer_ff[3:0] <= rx[3:0];
        end else if (wr_pend_ff) begin
            display_ram_write_pointer_ff <= display_ram_write_pointer_ff
                                            + ocd_pkg::ADDR_W'(1);
        end
    end

    // upper three bits simply do not exist no write clears it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            attribute_staging_ff <= ocd_pkg::RST_ATTR;
        end else if (cmd_attr) begin
            attribute_staging_ff <= rx[4:0];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            character_staging_ff <= ocd_pkg::RST_CHAR;
            wr_pend_ff           <= 1'b0;
        end else begin
            wr_pend_ff <= cmd_char;
            if (cmd_char) begin
                character_staging_ff <= nxt_char;
            end
        end
    end

    // the write is done one cycle after the load so that the staging
    // register already holds the new code; memory has no reset
    logic [ocd_pkg::WORD_W-1:0] disp_ram [ocd_pkg::RAM_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_pend_ff) begin
            disp_ram[display_ram_write_pointer_ff] <=
                {character_staging_ff, attribute_staging_ff};
        end
    end

    // ---------------- configuration ----------------
    ocd_pkg::ocd_cfg_t cfg_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff <= ocd_pkg::RST_CFG;
        end else begin
            if (cmd_divisor) begin
                cfg_ff.osc_divisor <= rx[5:0];
            end
            if (cmd_ctrl1) begin
                cfg_ff.scan_mode_hi       <= rx[3];
                cfg_ff.scan_mode_lo       <= rx[2];
                cfg_ff.video_out_polarity <= rx[1];
                cfg_ff.osd_clk_enable     <= rx[0];
            end
            if (cmd_sync) begin
                cfg_ff.hsync_in_polarity <= rx[3];
                cfg_ff.vsync_in_polarity <= rx[2];
                cfg_ff.display_mode_hi   <= rx[1];
                cfg_ff.display_mode_lo   <= rx[0];
            end
            if (cmd_blink) begin
                cfg_ff.blink_rate_hi <= rx[3];
                cfg_ff.blink_rate_lo <= rx[2];
                cfg_ff.blink_duty_hi <= rx[1];
                cfg_ff.blink_duty_lo <= rx[0];
            end
            if (cmd_io_sel) begin
                cfg_ff.io_port_select <= rx[2];
            end
            if (cmd_vstart_hi) begin
                cfg_ff.vstart[5:2] <= rx[3:0];
            end
            if (cmd_vh_start) begin
                cfg_ff.vstart[1:0] <= rx[3:2];
                cfg_ff.hstart[5:4] <= rx[1:0];
            end
            if (cmd_hstart_lo) begin
                cfg_ff.hstart[3:0] <= rx[3:0];
            end
            if (cmd_frame_bg) begin
                cfg_ff.frame_bg <= rx[3:0];
            end
            if (cmd_misc) begin
                cfg_ff.horiz_stabiliser_enable <= rx[3];
                cfg_ff.halftone_select         <= rx[2];
                cfg_ff.first_line_size_hi      <= rx[1];
                cfg_ff.first_line_size_lo      <= rx[0];
            end
        end
    end

    assign cfg = cfg_ff;

    logic port_bit0_ff;
    logic port_bit1_ff;
    logic port_bit4_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_bit0_ff <= 1'b0;
            port_bit1_ff <= 1'b0;
            port_bit4_ff <= 1'b0;
        end else if (cmd_port) begin
            port_bit4_ff <= rx[4];
            port_bit1_ff <= rx[1];
            port_bit0_ff <= rx[0];
        end
    end

    assign port_out_bit0 = port_bit0_ff;
    assign port_out_bit1 = port_bit1_ff;
    assign port_out_bit4 = port_bit4_ff;

    // ---------------- display side ----------------
    logic [ocd_pkg::WORD_W-1:0] cell_word_ff;
    logic                       cell_valid_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cell_word_ff  <= '0;
            cell_valid_ff <= 1'b0;
        end else begin
            cell_valid_ff <= cell_req;
            if (cell_req) begin
                cell_word_ff <= disp_ram[cell_addr];
            end
        end
    end

    assign cell_word  = cell_word_ff;
    assign cell_valid = cell_valid_ff;

    logic [7:0] cell_code;
    logic       is_cr;
    logic       is_space;
    logic       is_glyph;

    assign cell_code = cell_word_ff[ocd_pkg::WORD_W-1:ocd_pkg::CHAR_LSB];
    assign is_cr     = cell_code == ocd_pkg::CODE_CR;
    assign is_space  = cell_code == ocd_pkg::CODE_SPACE;
    assign is_glyph  = cell_code < ocd_pkg::CODE_TEST;

    // line state and space state carry over to the following cells
    ocd_pkg::ocd_line_t line_ff;
    logic [3:0]         space_bg_ff;
    logic               marker_on_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_ff <= '0;
        end else if (cell_valid_ff) begin
            line_ff.is_cr    <= is_cr;
            line_ff.is_space <= is_space;
            line_ff.code     <= cell_code;
            if (is_cr) begin
                line_ff.line_size     <= cell_word_ff[4:3];
                line_ff.line_spacing  <= cell_word_ff[2:1];
                line_ff.end_of_screen <= cell_word_ff[0];
            end
        end
    end

    assign line_info = line_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            space_bg_ff  <= '0;
            marker_on_ff <= 1'b0;
        end else if (cell_valid_ff && is_space) begin
            space_bg_ff  <= cell_word_ff[4:1];
            marker_on_ff <= cell_word_ff[0];
        end
    end

    // colours are resolved active-high, then folded to the pin polarity
    logic [3:0] nxt_rgbi;
    logic       nxt_fb;
    logic       nxt_marker;
    logic       pol;

    assign pol = cfg_ff.video_out_polarity;

    always_comb begin
        nxt_rgbi   = 4'h0;
        nxt_fb     = 1'b0;
        nxt_marker = 1'b0;
        if (cell_valid_ff && !retrace) begin
            if (is_glyph && glyph_dot && !(cell_word_ff[0] && blink_hide)) begin
                nxt_rgbi = cell_word_ff[4:1];
                nxt_fb   = 1'b1;
            end else if (is_space && SPACE_HAS_BG) begin
                nxt_rgbi = space_bg_ff;
                nxt_fb   = 1'b1;
            end
            nxt_marker = marker_on_ff && !is_cr;
        end
    end

    ocd_pkg::ocd_video_t video_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            video_ff <= '{default: ~ocd_pkg::RST_POLARITY};
        end else begin
            video_ff.red               <= nxt_rgbi[3] ~^ pol;
            video_ff.green             <= nxt_rgbi[2] ~^ pol;
            video_ff.blue              <= nxt_rgbi[1] ~^ pol;
            video_ff.intensity         <= nxt_rgbi[0] ~^ pol;
            video_ff.fast_blanking_out <= nxt_fb ~^ pol;
            video_ff.record_marker_out <= nxt_marker ~^ pol;
        end
    end

    assign video = video_ff;

endmodule
`default_nettype wire

// >>> ocd_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_decoder_asserts (
    input wire logic                       sys_clk,
    input wire logic                       sys_rst,
    input wire logic                       cell_req,
    input wire logic                       retrace,
    input wire logic                       byte_taken,
    input wire ocd_pkg::ocd_cfg_t          cfg,
    input wire logic                       port_out_bit0,
    input wire logic                       port_out_bit1,
    input wire logic                       port_out_bit4,
    input wire logic [1:0]                 bank,
    input wire logic [ocd_pkg::ADDR_W-1:0] wr_pointer,
    input wire logic [ocd_pkg::WORD_W-1:0] cell_word,
    input wire logic                       cell_valid,
    input wire ocd_pkg::ocd_line_t         line_info,
    input wire ocd_pkg::ocd_video_t        video
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    taken_pulse_a: assert property (byte_taken |=> !byte_taken)
        else $error("byte_taken held longer than one cycle");
    bank_hold_a: assert property (!$past(byte_taken) |-> $stable(bank))
        else $error("bank changed without a decoded byte");
    cfg_hold_a: assert property (!$past(byte_taken) |-> $stable(cfg))
        else $error("cfg changed without a decoded byte");
    port_hold_a: assert property (!$past(byte_taken)
        |-> $stable({port_out_bit4, port_out_bit1, port_out_bit0}))
        else $error("port bits changed without a decoded byte");
    // the increment lands one edge after the staging load, hence depth two
    ptr_cause_a: assert property ($changed(wr_pointer)
        |-> $past(byte_taken) || $past(byte_taken, 2))
        else $error("write pointer moved with no command");
    cell_valid_a: assert property (cell_req |=> cell_valid)
        else $error("cell_valid missing after cell_req");
    cr_line_a: assert property (cell_valid && cell_word[12:5] == ocd_pkg::CODE_CR
        |=> line_info.is_cr && line_info.line_size == $past(cell_word[4:3])
        && line_info.line_spacing == $past(cell_word[2:1])
        && line_info.end_of_screen == $past(cell_word[0]))
        else $error("carriage return fields wrong");
    space_line_a: assert property (cell_valid && cell_word[12:5] == ocd_pkg::CODE_SPACE
        |=> line_info.is_space && !line_info.is_cr)
        else $error("space word not flagged");
    retrace_off_a: assert property (retrace[*2]
        |-> video == {6{~cfg.video_out_polarity}})
        else $error("video active during retrace");

    cover property (byte_taken && bank == ocd_pkg::BANK_1);
    cover property (cell_valid && cell_word[12:5] == ocd_pkg::CODE_CR);
    cover property (retrace && cell_valid);
endmodule

bind ocd_decoder ocd_decoder_asserts u_ocd_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cell_req(cell_req), .retrace(retrace),
    .byte_taken(byte_taken), .cfg(cfg), .port_out_bit0(port_out_bit0),
    .port_out_bit1(port_out_bit1), .port_out_bit4(port_out_bit4), .bank(bank),
    .wr_pointer(wr_pointer), .cell_word(cell_word), .cell_valid(cell_valid),
    .line_info(line_info), .video(video)
);
`default_nettype wire

// >>> ocd_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_link_model (
    output logic                       link_clk,
    output logic [ocd_pkg::BYTE_W-1:0] link_byte,
    output logic                       link_byte_valid
);
    initial begin
        link_clk = 1'h0;
        link_byte = 8'h00;
        link_byte_valid = 1'h0;
    end

    // clock runs only within a frame; a few trailing edges flush the receiver
    task automatic send(input logic [ocd_pkg::BYTE_W-1:0] b);
        #2.3;
        link_clk = 1'h1;
        #6;
        link_clk = 1'h0;
        link_byte = b;
        link_byte_valid = 1'h1;
        #6;
        link_clk = 1'h1;
        #6;
        link_clk = 1'h0;
        link_byte_valid = 1'h0;
        // released data shows the inverse so stale values cannot pass
        link_byte = ~b;
        repeat (4) begin
            #6;
            link_clk = 1'h1;
            #6;
            link_clk = 1'h0;
        end
    endtask
endmodule
`default_nettype wire

// >>> ocd_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_decoder_test;
    logic                       sys_clk = 1'h0;
    logic                       sys_rst = 1'h1;
    logic                       link_clk;
    logic [ocd_pkg::BYTE_W-1:0] link_byte;
    logic                       link_byte_valid;
    logic                       cell_req = 1'h0;
    logic [ocd_pkg::ADDR_W-1:0] cell_addr = 8'h00;
    logic                       glyph_dot = 1'h0;
    logic                       blink_hide = 1'h0;
    logic                       retrace = 1'h0;
    logic                       byte_taken;
    ocd_pkg::ocd_cfg_t          cfg;
    ocd_pkg::ocd_cfg_t          exp_cfg;
    logic                       port_out_bit0;
    logic                       port_out_bit1;
    logic                       port_out_bit4;
    logic [1:0]                 bank;
    logic [ocd_pkg::ADDR_W-1:0] wr_pointer;
    logic [ocd_pkg::WORD_W-1:0] cell_word;
    logic [ocd_pkg::WORD_W-1:0] word;
    logic                       cell_valid;
    ocd_pkg::ocd_line_t         line_info;
    ocd_pkg::ocd_video_t        video;
    int                         err_total = 0;
    int                         checks_done = 0;
    int                         cycles = 0;

    ocd_decoder dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk), .link_byte(link_byte),
        .link_byte_valid(link_byte_valid), .cell_req(cell_req), .cell_addr(cell_addr),
        .glyph_dot(glyph_dot), .blink_hide(blink_hide), .retrace(retrace),
        .byte_taken(byte_taken), .cfg(cfg), .port_out_bit0(port_out_bit0),
        .port_out_bit1(port_out_bit1), .port_out_bit4(port_out_bit4), .bank(bank),
        .wr_pointer(wr_pointer), .cell_word(cell_word), .cell_valid(cell_valid),
        .line_info(line_info), .video(video)
    );
    ocd_link_model link_mdl (
        .link_clk(link_clk), .link_byte(link_byte), .link_byte_valid(link_byte_valid)
    );

    always #10 sys_clk = ~sys_clk;

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total = err_total + 1;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // spacing keeps bytes well beyond the six-cycle minimum
    task automatic send(input logic [7:0] b);
        link_mdl.send(b);
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic read_cell(input logic [7:0] a, output logic [12:0] w);
        cell_req = 1'h1;
        cell_addr = a;
        @(negedge sys_clk);
        cell_req = 1'h0;
        w = cell_word;
        @(negedge sys_clk);
    endtask

    task automatic t_reset;
        exp_cfg = ocd_pkg::RST_CFG;
        check("bank", 64'(bank), 64'h0);
        check("pointer", 64'(wr_pointer), 64'h0);
        check("cfg", 64'(cfg), 64'(exp_cfg));
    endtask

    task automatic t_pointer_and_write;
        send(8'h2A);
        check("pointer hi", 64'(wr_pointer), 64'hA0);
        send(8'h35);
        check("pointer lo", 64'(wr_pointer), 64'hA5);
        send(8'h13);
        send(8'h85);
        send(8'h86);
        check("pointer inc", 64'(wr_pointer), 64'hA7);
        read_cell(8'hA5, word);
        check("word a5", 64'(word), 64'({8'h05, 5'h13}));
        read_cell(8'hA6, word);
        check("word a6", 64'(word), 64'({8'h06, 5'h13}));
    endtask

    task automatic t_bank2;
        send(8'h7A);
        check("bank 2", 64'(bank), 64'h2);
        send(8'h0B);
        send(8'hFE);
        send(8'hFF);
        send(8'h25);
        check("pointer refused", 64'(wr_pointer), 64'hA9);
        read_cell(8'hA7, word);
        check("word a7", 64'(word), 64'({8'hFE, 5'h0B}));
        check("cr fields", 64'({line_info.is_cr, line_info.is_space, line_info.line_size,
            line_info.line_spacing, line_info.end_of_screen}), 64'h4B);
        read_cell(8'hA8, word);
        check("word a8", 64'(word), 64'({8'hFF, 5'h0B}));
        check("space flags", 64'({line_info.is_cr, line_info.is_space}), 64'h1);
    endtask

    task automatic t_bank1;
        send(8'h79);
        send(8'h85);
        check("pointer bank1", 64'(wr_pointer), 64'hA9);
        send(8'h2D);
        exp_cfg.osc_divisor = 6'h2D;
        check("divisor", 64'(cfg), 64'(exp_cfg));
        send(8'h4B);
        exp_cfg.scan_mode_hi = 1'h1;
        exp_cfg.osd_clk_enable = 1'h1;
        check("control", 64'(cfg), 64'(exp_cfg));
        send(8'h5E);
        exp_cfg.hsync_in_polarity = 1'h1;
        exp_cfg.vsync_in_polarity = 1'h1;
        exp_cfg.display_mode_hi = 1'h1;
        check("sync", 64'(cfg), 64'(exp_cfg));
        send(8'h9C);
        send(8'hA7);
        send(8'hB5);
        exp_cfg.vstart = 6'h31;
        exp_cfg.hstart = 6'h35;
        check("start", 64'(cfg), 64'(exp_cfg));
        send(8'hD3);
        check("ports set", 64'({port_out_bit4, port_out_bit1, port_out_bit0}), 64'h7);
        send(8'hEC);
        check("ports clr", 64'({port_out_bit4, port_out_bit1, port_out_bit0}), 64'h0);
    endtask

    task automatic t_bank0;
        send(8'h78);
        check("bank 0", 64'(bank), 64'h0);
        send(8'h46);
        send(8'h5B);
        exp_cfg.frame_bg = 4'h6;
        exp_cfg.horiz_stabiliser_enable = 1'h1;
        exp_cfg.first_line_size_hi = 1'h1;
        exp_cfg.first_line_size_lo = 1'h1;
        check("frame misc", 64'(cfg), 64'(exp_cfg));
    endtask

    task automatic t_retrace;
        retrace = 1'h1;
        glyph_dot = 1'h1;
        read_cell(8'hA5, word);
        check("video retrace", 64'(video), 64'h0);
        retrace = 1'h0;
        read_cell(8'hA5, word);
        check("video glyph", 64'(video), 64'h27);
        blink_hide = 1'h1;
        read_cell(8'hA5, word);
        check("video blink", 64'(video), 64'h01);
        blink_hide = 1'h0;
        glyph_dot = 1'h0;
    endtask

    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'h0;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_pointer_and_write();
        t_bank2();
        t_bank1();
        t_bank0();
        t_retrace();
        print_verdict();
    end
endmodule
`default_nettype wire
